// File: boabs_core.sv
// Operand address former and register bank selector.
// Assumes decoder events are single-cycle pulses on core_clk.
`timescale 1ns/1ps
module boabs_core
  import boabs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Operand request
  input wire logic req_valid,
  input wire boabs_req_t req,
  // Memory bank state
  input wire logic mem_bank_enable,
  input wire logic [3:0] mem_bank_select,
  // Bank control events
  input wire logic bit_set_instr,
  input wire logic bit_clear_instr,
  input wire logic sel_instr,
  input wire logic [1:0] sel_bank,
  input wire logic call_event,
  input wire logic ret_event,
  input wire logic int_entry,
  input wire logic int_vec_rbe,
  input wire logic int_return,
  input wire logic pop_pair,
  input wire logic [7:0] pop_data,
  // Operand answer
  output logic resp_valid,
  output boabs_resp_t resp,
  // Bank state
  output logic bank_enable_flag,
  output logic [3:0] bank_select,
  output logic [1:0] active_bank,
  output logic [7:0] bank_select_pair,
  output logic mbs_restore_valid,
  output logic [3:0] mbs_restore
);

  logic next_rbe;
  logic [3:0] next_sel;
  logic saved_rbe;
  logic stack_push;
  logic stack_pop;
  logic [3:0] eff_mb;
  boabs_resp_t next_resp;

  function automatic logic [1:0] bank_of(input logic en, input logic [3:0] sel);
    bank_of = en ? sel[1:0] : 2'h0;
  endfunction

  function automatic logic in_win(input logic [11:0] a, input logic [11:0] lo,
                                  input logic [11:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  assign stack_push = call_event || int_entry;
  assign stack_pop = ret_event || int_return;
  assign eff_mb = mem_bank_enable ? mem_bank_select : MB_ZERO;

  boabs_flag_stack u_flag_stack (
    .core_clk(core_clk),
    .reset(reset),
    .push(stack_push),
    .pop(stack_pop),
    .din(bank_enable_flag),
    .dout(saved_rbe)
  );

  // Next enable flag
  always_comb begin
    next_rbe = bank_enable_flag;
    if (int_entry) begin
      next_rbe = int_vec_rbe;
    end else if (stack_pop) begin
      next_rbe = saved_rbe;
    end else if (bit_set_instr) begin
      next_rbe = 1'b1;
    end else if (bit_clear_instr) begin
      next_rbe = 1'b0;
    end
  end

  // Next select register; upper bits held at zero
  always_comb begin
    next_sel = bank_select;
    if (sel_instr) begin
      next_sel = {2'h0, sel_bank};
    end else if (pop_pair) begin
      next_sel = {2'h0, pop_data[1:0]};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bank_enable_flag <= RST_RBE;
    end else begin
      bank_enable_flag <= next_rbe;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bank_select <= RST_SEL;
    end else begin
      bank_select <= next_sel;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active_bank <= RST_BANK;
    end else begin
      active_bank <= bank_of(next_rbe, next_sel);
    end
  end

  // Push image and memory select restore
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bank_select_pair <= '0;
      mbs_restore_valid <= 1'b0;
      mbs_restore <= '0;
    end else begin
      bank_select_pair <= {mem_bank_select, next_sel};
      mbs_restore_valid <= pop_pair;
      if (pop_pair) begin
        mbs_restore <= pop_data[7:4];
      end
    end
  end

  // Operand address formation
  always_comb begin
    next_resp = '0;
    case (req.mode)
      MODE_FMEM: begin
        next_resp.addr = req.op_addr;
        next_resp.bit_num = req.op_bit;
        next_resp.fault = !(in_win(req.op_addr, FMEM_PORT_LO, FMEM_PORT_HI)
          || in_win(req.op_addr, FMEM_INT_LO, FMEM_INT_HI));
      end
      MODE_PMEM: begin
        next_resp.addr = {req.op_addr[11:2], req.l_reg[3:2]};
        next_resp.bit_num = req.l_reg[1:0];
        next_resp.fault = !in_win({req.op_addr[11:2], 2'h0}, PMEM_LO, PMEM_HI);
      end
      MODE_HMEM: begin
        next_resp.addr = {eff_mb, req.h_reg, req.op_addr[3:0]};
        next_resp.bit_num = req.op_bit;
      end
      MODE_STACK: begin
        next_resp.addr = {STACK_BANK, req.sp};
      end
      MODE_REG4: begin
        next_resp.addr = {REG_BANK, 3'h0, bank_of(bank_enable_flag, bank_select),
                          req.reg_idx};
      end
      MODE_REG8: begin
        next_resp.addr = {REG_BANK, 3'h0,
                          bank_of(bank_enable_flag, bank_select) ^ {1'b0, req.primed},
                          req.reg_idx[2:1], 1'b0};
      end
      default: begin
        next_resp.fault = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= req_valid;
      if (req_valid) begin
        resp <= next_resp;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  logic [1:0] act_now;
  assign act_now = bank_of(bank_enable_flag, bank_select);

  a_fmem_window: assert property (
    req_valid && req.mode == MODE_FMEM |=> resp_valid &&
      resp.fault == !($past(req.op_addr) >= 12'hff0 ||
      ($past(req.op_addr) >= 12'hfb0 && $past(req.op_addr) <= 12'hfbf)))
    else $error("bit-direct window check wrong");

  a_fmem_no_bank: assert property (
    req_valid && req.mode == MODE_FMEM |=> resp.addr == $past(req.op_addr))
    else $error("bit-direct address altered by bank");

  a_pmem_range: assert property (
    req_valid && req.mode == MODE_PMEM |=> resp.fault == ($past(req.op_addr) < 12'hfc0))
    else $error("port indirect range wrong");

  a_pmem_split: assert property (
    req_valid && req.mode == MODE_PMEM |=>
      resp.addr[11:2] == $past(req.op_addr[11:2]) &&
      resp.addr[1:0] == $past(req.l_reg[3:2]) && resp.bit_num == $past(req.l_reg[1:0]))
    else $error("port indirect split wrong");

  a_hmem_form: assert property (
    req_valid && req.mode == MODE_HMEM |=>
      resp.addr == {$past(eff_mb), $past(req.h_reg), $past(req.op_addr[3:0])})
    else $error("H-plus address wrong");

  a_stack_bank: assert property (
    req_valid && req.mode == MODE_STACK |=> resp.addr == {4'h0, $past(req.sp)})
    else $error("stack address not in bank 0");

  a_reg_map: assert property (
    req_valid && req.mode == MODE_REG4 |=>
      resp.addr[11:5] == 7'h0 && resp.addr[4:3] == $past(act_now))
    else $error("register address outside bank area");

  a_bank_and: assert property (
    active_bank == (bank_enable_flag ? bank_select[1:0] : 2'h0))
    else $error("active bank mismatch");

  a_sel_upper: assert property (
    bank_select[3:2] == 2'h0)
    else $error("select upper bits nonzero");

  a_call_restore: assert property (
    call_event && !int_entry ##1 bit_set_instr && !stack_pop && !int_entry
      ##1 ret_event && !stack_push |=> bank_enable_flag == $past(bank_enable_flag, 3))
    else $error("flag not restored on return");

  a_int_load: assert property (
    int_entry |=> bank_enable_flag == $past(int_vec_rbe))
    else $error("interrupt flag not loaded");

  a_sel_load: assert property (
    sel_instr |=> bank_select == {2'h0, $past(sel_bank)})
    else $error("select instruction not applied");

  a_primed_pair: assert property (
    req_valid && req.mode == MODE_REG8 && req.primed |=>
      resp.addr[4:3] == ($past(act_now) ^ 2'h1) && !resp.addr[0])
    else $error("primed pair bank wrong");

  a_fmem_bit: assert property (
    req_valid && req.mode == MODE_FMEM |=>
      resp.bit_num == $past(req.op_bit))
    else $error("bit-direct bit number wrong");

  a_pmem_no_bank: assert property (
    req_valid && req.mode == MODE_PMEM |=>
      resp.addr == {$past(req.op_addr[11:2]), $past(req.l_reg[3:2])})
    else $error("port indirect address altered by bank");

  a_pmem_bit: assert property (
    req_valid && req.mode == MODE_PMEM |=>
      resp.bit_num == $past(req.l_reg[1:0]))
    else $error("port indirect bit number wrong");

  // Interrupt with no other flag event between entry and return
  a_int_restore: assert property (
    int_entry ##1 !stack_push && !stack_pop && !bit_set_instr && !bit_clear_instr
      ##1 int_return && !stack_push |=> bank_enable_flag == $past(bank_enable_flag, 3))
    else $error("flag not restored on interrupt return");

  a_pop_sel: assert property (
    pop_pair && !sel_instr |=>
      bank_select == {2'h0, $past(pop_data[1:0])})
    else $error("select not reloaded by pop");

  a_mbs_restore: assert property (
    pop_pair |=>
      mbs_restore_valid && mbs_restore == $past(pop_data[7:4]))
    else $error("memory select not restored by pop");

  a_flag_set: assert property (
    bit_set_instr && !int_entry && !stack_pop |=>
      bank_enable_flag)
    else $error("flag not set");

  a_flag_clear: assert property (
    bit_clear_instr && !bit_set_instr && !int_entry && !stack_pop |=>
      !bank_enable_flag)
    else $error("flag not cleared");

  a_pair_even: assert property (
    req_valid && req.mode == MODE_REG8 |=>
      !resp.addr[0] && resp.addr[2:1] == $past(req.reg_idx[2:1]))
    else $error("register pair address not even");

  a_plain_pair: assert property (
    req_valid && req.mode == MODE_REG8 && !req.primed |=>
      resp.addr[4:3] == $past(act_now))
    else $error("unprimed pair bank wrong");

  a_stack_fixed: assert property (
    req_valid && req.mode == MODE_STACK |=>
      resp.addr[11:8] == 4'h0 && !resp.fault)
    else $error("stack access outside bank 0");

  a_flag_off_bank: assert property (
    !bank_enable_flag |->
      active_bank == 2'h0)
    else $error("bank not 0 with flag clear");

  c_fmem_hit: cover property (req_valid && req.mode == MODE_FMEM ##1 !resp.fault);
  c_primed: cover property (req_valid && req.mode == MODE_REG8 && req.primed);
  c_int_cycle: cover property (int_entry ##[1:20] int_return);
  c_bank3: cover property (active_bank == 2'h3);
  c_pmem_step: cover property (req_valid && req.mode == MODE_PMEM && req.l_reg == 4'hf);

endmodule

// File: boabs_pkg.sv
// Package for the bit operand and register bank select block.
// Assumes one core clock domain; all requests come from the decoder.
package boabs_pkg;

  // Data memory address layout and flag stack size
  localparam int ADDR_W = 12;
  localparam int SP_W = 8;
  localparam int FLAG_DEPTH = 8;
  localparam int FLAG_PTR_W = 4;

  // Bit-direct and port indirect windows
  localparam logic [11:0] FMEM_PORT_LO = 12'hff0;
  localparam logic [11:0] FMEM_PORT_HI = 12'hfff;
  localparam logic [11:0] FMEM_INT_LO = 12'hfb0;
  localparam logic [11:0] FMEM_INT_HI = 12'hfbf;
  localparam logic [11:0] PMEM_LO = 12'hfc0;
  localparam logic [11:0] PMEM_HI = 12'hfff;

  // Fixed banks
  localparam logic [3:0] STACK_BANK = 4'h0;
  localparam logic [3:0] REG_BANK = 4'h0;
  localparam logic [3:0] MB_ZERO = 4'h0;

  // Reset values
  localparam logic RST_RBE = 1'b0;
  localparam logic [3:0] RST_SEL = 4'h0;
  localparam logic [1:0] RST_BANK = 2'h0;

  typedef enum logic [2:0] {
    MODE_FMEM = 3'h0,
    MODE_PMEM = 3'h1,
    MODE_HMEM = 3'h2,
    MODE_STACK = 3'h3,
    MODE_REG4 = 3'h4,
    MODE_REG8 = 3'h5
  } boabs_mode_t;

  // One operand request from the decoder
  typedef struct packed {
    boabs_mode_t mode;
    logic [11:0] op_addr;
    logic [1:0] op_bit;
    logic [3:0] h_reg;
    logic [3:0] l_reg;
    logic [7:0] sp;
    logic [2:0] reg_idx;
    logic primed;
  } boabs_req_t;

  // Formed operand for the data memory
  typedef struct packed {
    logic [11:0] addr;
    logic [1:0] bit_num;
    logic fault;
  } boabs_resp_t;

endpackage

// File: boabs_flag_stack.sv
// Save stack for the bank enable flag across calls and interrupts.
// Assumes push and pop never arrive together; a push onto a full stack is lost.
`timescale 1ns/1ps
module boabs_flag_stack
  import boabs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic din,
  output logic dout
);

  logic slots [FLAG_DEPTH];
  logic [FLAG_PTR_W-1:0] depth;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      depth <= '0;
    end else if (push && depth != FLAG_PTR_W'(FLAG_DEPTH)) begin
      depth <= depth + 1'b1;
    end else if (pop && depth != '0) begin
      depth <= depth - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push && depth != FLAG_PTR_W'(FLAG_DEPTH)) begin
      slots[depth[2:0]] <= din;
    end
  end

  // Empty stack restores a cleared flag
  always_comb begin
    if (depth == '0) begin
      dout = RST_RBE;
    end else begin
      dout = slots[3'(depth - 1'b1)];
    end
  end

endmodule

// File: boabs_mem_model.sv
// Banked data memory side: logs each operand address the block forms.
// Assumes resp_valid is a one-cycle pulse per accepted request.
`timescale 1ns/1ps
module boabs_mem_model
  import boabs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Operand from the block
  input wire logic resp_valid,
  input wire boabs_resp_t resp,
  // Observation
  output logic [11:0] last_addr,
  output logic [15:0] n_acc
);
  // One access per answer pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last_addr <= 12'h000;
      n_acc <= 16'h0000;
    end else if (resp_valid) begin
      last_addr <= resp.addr;
      n_acc <= n_acc + 16'h0001;
    end
  end
endmodule

// File: bit_operand_and_bank_select_tb.sv
// Testbench for the operand former and register bank selector.
// Assumes the decoder contract: one-cycle answers, bank updates a cycle later.
`timescale 1ns/1ps
module bit_operand_and_bank_select_tb;
  import boabs_pkg::*;
  logic core_clk, reset, req_valid, mem_bank_enable, resp_valid, bank_enable_flag;
  logic mbs_restore_valid;
  boabs_req_t req;
  boabs_resp_t resp;
  logic [3:0] mem_bank_select, bank_select, mbs_restore;
  logic [1:0] active_bank;
  logic [7:0] ev, d, bank_select_pair;
  logic [11:0] last_addr;
  logic [15:0] n_acc, n_req;
  logic [14:0] msk;
  logic [11:0] fa [8] = '{12'hff0, 12'hfff, 12'hfb0, 12'hfbf, 12'hfef, 12'hfc0, 12'hfaf,
    12'hf00};
  int n_fail, num_checks, cyc;

  boabs_core DUT (
    .core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .mem_bank_enable(mem_bank_enable), .mem_bank_select(mem_bank_select),
    .bit_set_instr(ev[7]), .bit_clear_instr(ev[6]), .sel_instr(ev[5]),
    .sel_bank(d[1:0]), .call_event(ev[4]), .ret_event(ev[3]), .int_entry(ev[2]),
    .int_vec_rbe(d[0]), .int_return(ev[1]), .pop_pair(ev[0]), .pop_data(d),
    .resp_valid(resp_valid), .resp(resp), .bank_enable_flag(bank_enable_flag),
    .bank_select(bank_select), .active_bank(active_bank),
    .bank_select_pair(bank_select_pair), .mbs_restore_valid(mbs_restore_valid),
    .mbs_restore(mbs_restore)
  );

  boabs_mem_model mem (
    .core_clk(core_clk), .reset(reset), .resp_valid(resp_valid), .resp(resp),
    .last_addr(last_addr), .n_acc(n_acc)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic op(input boabs_mode_t m, input logic [11:0] a, input logic [1:0] b,
                    input logic [3:0] h, input logic [3:0] l, input logic [7:0] s,
                    input logic [2:0] i, input logic p, input logic [14:0] e);
    @(posedge core_clk);
    req <= '{m, a, b, h, l, s, i, p};
    req_valid <= 1'b1;
    n_req <= n_req + 16'h0001;
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    chk("resp_valid", {15'h0, resp_valid}, 16'h0001);
    chk("resp", {1'b0, resp & msk}, {1'b0, e & msk});
  endtask

  task automatic pulse(input logic [7:0] e, input logic [7:0] v);
    @(posedge core_clk);
    ev <= e;
    d <= v;
    @(posedge core_clk);
    ev <= 8'h00;
    #1;
  endtask

  task automatic bk(input logic f, input logic [3:0] s, input logic [1:0] a);
    chk("bank", {9'h0, bank_enable_flag, bank_select, active_bank}, {9'h0, f, s, a});
  endtask

  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    mem_bank_enable = 1'b1;
    mem_bank_select = 4'h5;
    ev = 8'h00;
    d = 8'h00;
    n_req = 16'h0000;
    msk = '1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    bk(1'b0, 4'h0, 2'h0);
    foreach (fa[k]) op(MODE_FMEM, fa[k], 2'h3, 4'h0, 4'h0, 8'h0, 3'h0, 1'b0, {fa[k], 2'h3, k > 3});
    for (int k = 0; k < 16; k++) op(MODE_PMEM, 12'hfd0, 2'h0, 4'h0, 4'(k), 8'h0, 3'h0, 1'b0, {10'h3f4, 2'(k >> 2), 2'(k), 1'b0});
    op(MODE_PMEM, 12'hfbc, 2'h0, 4'h0, 4'h0, 8'h0, 3'h0, 1'b0, {12'hfbc, 2'h0, 1'b1});
    op(MODE_HMEM, 12'h03a, 2'h1, 4'h7, 4'h0, 8'h0, 3'h0, 1'b0, {12'h57a, 2'h1, 1'b0});
    msk = 15'h7ff9;
    op(MODE_STACK, 12'h000, 2'h0, 4'h0, 4'h0, 8'ha5, 3'h0, 1'b0, {12'h0a5, 2'h0, 1'b0});
    @(posedge core_clk) mem_bank_enable <= 1'b0;
    op(MODE_HMEM, 12'h03a, 2'h1, 4'h7, 4'h0, 8'h0, 3'h0, 1'b0, {12'h07a, 2'h1, 1'b0});
    pulse(8'h20, 8'h02);
    bk(1'b0, 4'h2, 2'h0);
    pulse(8'h80, 8'h00);
    bk(1'b1, 4'h2, 2'h2);
    for (int k = 0; k < 4; k++) begin
      pulse(8'h20, 8'(k));
      bk(1'b1, 4'(k), 2'(k));
    end
    op(MODE_REG4, 12'h000, 2'h0, 4'h0, 4'h0, 8'h0, 3'h5, 1'b0, {12'h01d, 2'h0, 1'b0});
    op(MODE_REG8, 12'h000, 2'h0, 4'h0, 4'h0, 8'h0, 3'h5, 1'b1, {12'h014, 2'h0, 1'b0});
    op(MODE_REG8, 12'h000, 2'h0, 4'h0, 4'h0, 8'h0, 3'h5, 1'b0, {12'h01c, 2'h0, 1'b0});
    pulse(8'h10, 8'h00);
    pulse(8'h40, 8'h00);
    bk(1'b0, 4'h3, 2'h0);
    pulse(8'h08, 8'h00);
    bk(1'b1, 4'h3, 2'h3);
    pulse(8'h40, 8'h00);
    pulse(8'h04, 8'h01);
    bk(1'b1, 4'h3, 2'h3);
    pulse(8'h02, 8'h00);
    bk(1'b0, 4'h3, 2'h0);
    @(posedge core_clk) ev <= 8'h10;
    @(posedge core_clk) ev <= 8'h80;
    @(posedge core_clk) ev <= 8'h08;
    @(posedge core_clk) ev <= 8'h00;
    #1;
    bk(1'b0, 4'h3, 2'h0);
    pulse(8'h04, 8'h00);
    bk(1'b0, 4'h3, 2'h0);
    pulse(8'h02, 8'h00);
    bk(1'b0, 4'h3, 2'h0);
    pulse(8'h01, 8'h9e);
    chk("restore", {11'h0, mbs_restore_valid, mbs_restore}, 16'h0019);
    @(posedge core_clk);
    #1;
    chk("pair", {7'h0, mbs_restore_valid, bank_select_pair}, 16'h0052);
    chk("accesses", n_acc, n_req);
    summarize();
  end
endmodule
